//--- ocd_pkg.sv
package ocd_pkg;

	// tool port offsets
	localparam logic [1:0] OCD_OFF_OPT0   = 2'h0;
	localparam logic [1:0] OCD_OFF_OPT1   = 2'h1;
	localparam logic [1:0] OCD_OFF_STATUS = 2'h2;
	localparam logic [1:0] OCD_OFF_CMD    = 2'h3;

	// option byte 0 fields
	localparam int OCD_B0_STOP_RST  = 7;
	localparam int OCD_B0_WDG_KIND  = 6;
	localparam int OCD_B0_CLK_SAFE  = 5;
	localparam int OCD_B0_VD_HI     = 4;
	localparam int OCD_B0_VD_LO     = 3;
	localparam int OCD_B0_PKG_LO    = 1;
	localparam int OCD_B0_RD_LOCK   = 0;

	// option byte 1 fields
	localparam int OCD_B1_PKG_HI    = 7;
	localparam int OCD_B1_RST_DLY   = 6;
	localparam int OCD_B1_SRC_HI    = 5;
	localparam int OCD_B1_SRC_LO    = 4;
	localparam int OCD_B1_RNG_HI    = 3;
	localparam int OCD_B1_RNG_LO    = 1;
	localparam int OCD_B1_DBL_OFF   = 0;

	// command register bits
	localparam int OCD_CMD_ERASE    = 0;

	// status register bits
	localparam int OCD_ST_PROG      = 0;
	localparam int OCD_ST_BUSY      = 1;
	localparam int OCD_ST_LOCKED    = 2;
	localparam int OCD_ST_BAD_COMBO = 3;

	// storage values
	localparam logic [7:0] OCD_ERASED    = 8'hFF;
	localparam logic [7:0] OCD_SHIP_OPT0 = 8'hE7;
	localparam logic [7:0] OCD_SHIP_OPT1 = 8'hEF;

	// decode encodings
	localparam logic [1:0] OCD_VD_OFF     = 2'h3;
	localparam logic [1:0] OCD_VD_HIGHEST = 2'h0;
	localparam logic [1:0] OCD_SRC_RESON  = 2'h0;
	localparam logic [1:0] OCD_SRC_EXT_RC = 2'h1;
	localparam logic [1:0] OCD_SRC_INT_RC = 2'h2;
	localparam logic [1:0] OCD_SRC_EXT    = 2'h3;

	// reset phase lengths in processor cycles
	localparam logic [12:0] OCD_RST_CYC_LONG  = 13'h1000;
	localparam logic [12:0] OCD_RST_CYC_SHORT = 13'h0100;

	typedef enum logic [2:0] {
		OCD_SEQ_IDLE = 3'b001,
		OCD_SEQ_USER = 3'b010,
		OCD_SEQ_OPT  = 3'b100
	} ocd_seq_e;

endpackage

//--- ocd_option_store.sv
`timescale 1ns/1ps
`default_nettype none
module ocd_option_store
	import ocd_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       nvInit,
	input  wire logic       wrEn,
	input  wire logic       wrSel,
	input  wire logic [7:0] wrData,
	input  wire logic       eraseEn,
	output logic      [7:0] opt0,
	output logic      [7:0] opt1
);
	// non-volatile cells: not touched by srst, only by power-on init, erase and tool writes
	logic [7:0] cell_ff [0:1];

	always_ff @(posedge ref_clk) begin
		if (nvInit) begin
			cell_ff[0] <= OCD_SHIP_OPT0; // R11
			cell_ff[1] <= OCD_SHIP_OPT1; // R11
		end else if (eraseEn) begin
			cell_ff[0] <= OCD_ERASED; // R2
			cell_ff[1] <= OCD_ERASED; // R2
		end else if (wrEn) begin
			cell_ff[wrSel] <= wrData;
		end
	end

	assign opt0 = cell_ff[0];
	assign opt1 = cell_ff[1];
endmodule
`default_nettype wire

//--- ocd_erase_seq.sv
`timescale 1ns/1ps
`default_nettype none
module ocd_erase_seq
	import ocd_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic srst,
	input  wire logic eraseReq,
	input  wire logic lockActive,
	input  wire logic userEraseDone,
	output logic      userEraseReq,
	output logic      optEraseEn,
	output logic      busy
);
	ocd_seq_e state_ff;
	ocd_seq_e nxt_state;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			OCD_SEQ_IDLE: begin
				if (eraseReq && lockActive) begin
					nxt_state = OCD_SEQ_USER; // R9
				end else if (eraseReq) begin
					nxt_state = OCD_SEQ_OPT;
				end
			end
			OCD_SEQ_USER: begin
				// options stay intact until user memory is gone
				if (userEraseDone) begin
					nxt_state = OCD_SEQ_OPT; // R9
				end
			end
			OCD_SEQ_OPT: nxt_state = OCD_SEQ_IDLE;
			default:     nxt_state = OCD_SEQ_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_ff <= OCD_SEQ_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign userEraseReq = (state_ff == OCD_SEQ_USER);
	assign optEraseEn   = (state_ff == OCD_SEQ_OPT);
	assign busy         = (state_ff != OCD_SEQ_IDLE);
endmodule
`default_nettype wire

//--- ocd_option_decoder.sv
// Summary of operation
// R1: option bytes have no memory-map address; tool reaches them only in programming mode.
// R2: erased option storage reads back as FFh.
// R3: stop-entry bit 1 with watchdog active makes stop entry reset.
// R4: watchdog kind 0 means watchdog always on in hardware.
// R5: clock safety bit 0 enables filter and backup oscillator; 1 disables.
// R6: voltage field 11 off, 00 highest threshold, 10/01 unused lower levels.
// R7: package low bit joins package high bit from byte 1.
// R8: read-out lock bit 0 protects user memory in test and programming modes.
// R9: erasing options under read-out lock erases user memory first.
// R10: tool must not enable low supply detector with read-out lock.
// R11: shipped programmable parts select the internal RC clock source.
// R12: factory-coded parts take fixed configuration, not stored option bytes.
// R13: reset delay bit 0 gives 4096 cycles, 1 gives 256.
// R14: clock source field picks resonator, external RC, internal RC, external.
// R15: oscillator range field picks resonator drive range 1-2 to 8-16 MHz.
// R16: doubler-off bit 0 multiplies clock by two; 1 bypasses.
// R17: both bytes latched during reset, outputs held until next reset.
// R18: each decoded field is its own output.
`timescale 1ns/1ps
`default_nettype none
module ocd_option_decoder
	import ocd_pkg::*;
#(
	parameter bit         FACTORY_CODED = 1'b0,
	parameter logic [7:0] FACTORY_OPT0  = 8'hFF,
	parameter logic [7:0] FACTORY_OPT1  = 8'hFF
)
(
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        nvInit,
	input  wire logic        progModePin,
	input  wire logic [1:0]  toolAddr,
	input  wire logic [7:0]  toolWrData,
	input  wire logic        toolWrStb,
	input  wire logic        toolRdStb,
	output logic      [7:0]  toolRdData,
	input  wire logic        userEraseDone,
	output logic             userEraseReq,
	input  wire logic        swWatchdogEn,
	input  wire logic        stopEntry,
	output logic             stopEntryReset,
	output logic             stopEntryResetSel,
	output logic             watchdogKindSel,
	output logic             watchdogHwOn,
	output logic             watchdogActive,
	output logic             clockSafetyDisable,
	output logic             clockSafetyEn,
	output logic      [1:0]  voltageDetectLevel,
	output logic             lowSupplyDetectorEn,
	output logic             auxSupplyDetectorEn,
	output logic             voltageThresholdHighest,
	output logic             voltageLevelUnused,
	output logic      [1:0]  packageSel,
	output logic             readoutLockN,
	output logic             readoutProtect,
	output logic             unsupportedCombo,
	output logic             resetDelaySel,
	output logic      [12:0] resetDelayCycles,
	output logic      [1:0]  clockSourceSel,
	output logic      [2:0]  oscillatorRangeSel,
	output logic             freqDoublerEn
);

	// decoded reset phase length, selected by the latched reset delay bit of byte 1
	function automatic logic [12:0] rstCycles(input logic sel);
		rstCycles = sel ? OCD_RST_CYC_SHORT : OCD_RST_CYC_LONG;
	endfunction

	// programming mode pin comes from outside: two flops before use
	logic progMeta_ff;
	logic progSync_ff;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			progMeta_ff <= 1'b0;
			progSync_ff <= 1'b0;
		end else begin
			progMeta_ff <= progModePin;
			progSync_ff <= progMeta_ff;
		end
	end

	// tool accesses only count in programming mode
	logic toolWr;
	logic toolRd;
	logic optWrEn;
	logic eraseCmd;

	assign toolWr   = toolWrStb && progSync_ff; // R1
	assign toolRd   = toolRdStb && progSync_ff; // R1
	assign optWrEn  = toolWr && !toolAddr[1]; // R1
	assign eraseCmd = toolWr && (toolAddr == OCD_OFF_CMD) &&
		toolWrData[OCD_CMD_ERASE];

	// storage and erase sequencing
	logic [7:0] storeOpt0;
	logic [7:0] storeOpt1;
	logic       optEraseEn;
	logic       seqBusy;
	logic       storeWrEn;

	// writes are dropped while an erase is under way
	assign storeWrEn = optWrEn && !seqBusy;

	ocd_option_store u_store (
		.ref_clk (ref_clk),
		.nvInit  (nvInit),
		.wrEn    (storeWrEn),
		.wrSel   (toolAddr[0]),
		.wrData  (toolWrData),
		.eraseEn (optEraseEn),
		.opt0    (storeOpt0),
		.opt1    (storeOpt1)
	);

	// effective source of the configuration
	logic [7:0] srcOpt0;
	logic [7:0] srcOpt1;

	assign srcOpt0 = FACTORY_CODED ? FACTORY_OPT0 : storeOpt0; // R12
	assign srcOpt1 = FACTORY_CODED ? FACTORY_OPT1 : storeOpt1; // R12

	ocd_erase_seq u_erase (
		.ref_clk       (ref_clk),
		.srst          (srst),
		.eraseReq      (eraseCmd && !FACTORY_CODED),
		.lockActive    (!storeOpt0[OCD_B0_RD_LOCK]), // R9
		.userEraseDone (userEraseDone),
		.userEraseReq  (userEraseReq),
		.optEraseEn    (optEraseEn),
		.busy          (seqBusy)
	);

	// configuration latched while srst is high, frozen afterwards
	logic [7:0] cfg0_ff;
	logic [7:0] cfg1_ff;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cfg0_ff <= srcOpt0; // R17
			cfg1_ff <= srcOpt1; // R17
		end
	end

	// byte 0 decode
	assign stopEntryResetSel  = cfg0_ff[OCD_B0_STOP_RST]; // R18
	assign watchdogKindSel    = cfg0_ff[OCD_B0_WDG_KIND]; // R18
	assign watchdogHwOn       = !cfg0_ff[OCD_B0_WDG_KIND]; // R4
	assign clockSafetyDisable = cfg0_ff[OCD_B0_CLK_SAFE]; // R18
	assign clockSafetyEn      = !cfg0_ff[OCD_B0_CLK_SAFE]; // R5
	assign voltageDetectLevel = cfg0_ff[OCD_B0_VD_HI:OCD_B0_VD_LO]; // R6
	assign lowSupplyDetectorEn = voltageDetectLevel != OCD_VD_OFF; // R6
	assign auxSupplyDetectorEn = voltageDetectLevel != OCD_VD_OFF; // R6
	assign voltageThresholdHighest =
		voltageDetectLevel == OCD_VD_HIGHEST; // R6
	// lower thresholds pass through but are flagged as unsupported levels
	assign voltageLevelUnused = lowSupplyDetectorEn &&
		!voltageThresholdHighest; // R6
	assign packageSel = {cfg1_ff[OCD_B1_PKG_HI],
		cfg0_ff[OCD_B0_PKG_LO]}; // R7
	assign readoutLockN   = cfg0_ff[OCD_B0_RD_LOCK]; // R18
	assign readoutProtect = !cfg0_ff[OCD_B0_RD_LOCK]; // R8
	// only reported: enforcing it is up to the programming tool
	assign unsupportedCombo = readoutProtect && lowSupplyDetectorEn; // R10

	// byte 1 decode
	assign resetDelaySel      = cfg1_ff[OCD_B1_RST_DLY]; // R18
	assign resetDelayCycles   = rstCycles(resetDelaySel); // R13
	assign clockSourceSel     = cfg1_ff[OCD_B1_SRC_HI:OCD_B1_SRC_LO]; // R14
	assign oscillatorRangeSel = cfg1_ff[OCD_B1_RNG_HI:OCD_B1_RNG_LO]; // R15
	assign freqDoublerEn      = !cfg1_ff[OCD_B1_DBL_OFF]; // R16

	// watchdog and stop entry
	assign watchdogActive = watchdogHwOn || swWatchdogEn; // R4

	logic stopRst_ff;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			stopRst_ff <= 1'b0;
		end else begin
			stopRst_ff <= stopEntry && watchdogActive &&
				stopEntryResetSel; // R3
		end
	end

	assign stopEntryReset = stopRst_ff;

	// tool read port: data one cycle after the strobe, zero otherwise
	logic [7:0] nxt_rdData;
	logic [7:0] rdData_ff;
	logic [7:0] statusWord;

	always_comb begin
		statusWord = 8'h00;
		statusWord[OCD_ST_PROG]      = progSync_ff;
		statusWord[OCD_ST_BUSY]      = seqBusy;
		statusWord[OCD_ST_LOCKED]    = readoutProtect;
		statusWord[OCD_ST_BAD_COMBO] = unsupportedCombo;
	end

	always_comb begin
		nxt_rdData = 8'h00;
		if (toolRd) begin // R1
			case (toolAddr)
				OCD_OFF_OPT0:   nxt_rdData = srcOpt0; // R2
				OCD_OFF_OPT1:   nxt_rdData = srcOpt1; // R2
				OCD_OFF_STATUS: nxt_rdData = statusWord;
				default:        nxt_rdData = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdData_ff <= 8'h00;
		end else begin
			rdData_ff <= nxt_rdData;
		end
	end

	assign toolRdData = rdData_ff;

endmodule
`default_nettype wire

//--- ocd_option_decoder_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ocd_option_decoder_monitor (
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic        progModePin,
	input wire logic        toolRdStb,
	input wire logic [7:0]  toolRdData,
	input wire logic        stopEntry,
	input wire logic        stopEntryReset,
	input wire logic        stopEntryResetSel,
	input wire logic        watchdogKindSel,
	input wire logic        watchdogActive,
	input wire logic [1:0]  voltageDetectLevel,
	input wire logic        lowSupplyDetectorEn,
	input wire logic        readoutLockN,
	input wire logic        unsupportedCombo,
	input wire logic        resetDelaySel,
	input wire logic [12:0] resetDelayCycles,
	input wire logic [1:0]  packageSel
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	a_stop_reset: assert property (stopEntry && watchdogActive &&
		stopEntryResetSel |=> stopEntryReset) else $error("no stop reset");
	a_stop_quiet: assert property (!stopEntryResetSel |=>
		!stopEntryReset) else $error("stray stop reset");
	a_hw_watchdog: assert property (!watchdogKindSel |->
		watchdogActive) else $error("hw watchdog off");
	a_vd_off: assert property (voltageDetectLevel == 2'h3 |->
		!lowSupplyDetectorEn) else $error("detector not off");
	a_lock_combo: assert property (unsupportedCombo ==
		(!readoutLockN && lowSupplyDetectorEn)) else $error("combo flag");
	a_reset_delay: assert property (resetDelayCycles ==
		(resetDelaySel ? 13'h0100 : 13'h1000)) else $error("delay count");
	a_cfg_held: assert property (!$past(srst) |->
		$stable({packageSel, readoutLockN, resetDelaySel}))
		else $error("config moved");
	a_rd_idle: assert property (!toolRdStb |=>
		toolRdData == 8'h00) else $error("read data not idle");
	a_rd_refused: assert property (!progModePin [*3] ##1 toolRdStb |=>
		toolRdData == 8'h00) else $error("read outside prog mode");
endmodule
bind ocd_option_decoder ocd_option_decoder_monitor mon_i (.ref_clk, .srst,
	.progModePin, .toolRdStb, .toolRdData, .stopEntry, .stopEntryReset,
	.stopEntryResetSel, .watchdogKindSel, .watchdogActive,
	.voltageDetectLevel, .lowSupplyDetectorEn, .readoutLockN,
	.unsupportedCombo, .resetDelaySel, .resetDelayCycles, .packageSel);
`default_nettype wire

//--- ocd_tool_model.sv
`timescale 1ns/1ps
`default_nettype none
module ocd_tool_model (
	input  wire logic       ref_clk,
	output logic      [1:0] toolAddr,
	output logic      [7:0] toolWrData,
	output logic            toolWrStb,
	output logic            toolRdStb,
	input  wire logic [7:0] toolRdData
);
	initial begin
		toolAddr = 2'h0;
		toolWrData = 8'h00;
		toolWrStb = 1'b0;
		toolRdStb = 1'b0;
	end
	// one-cycle strobes; data inverted after use so stale values never match
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		toolAddr <= a;
		toolWrData <= d;
		toolWrStb <= 1'b1;
		@(posedge ref_clk);
		toolWrStb <= 1'b0;
		toolWrData <= ~d;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		toolAddr <= a;
		toolRdStb <= 1'b1;
		@(posedge ref_clk);
		toolRdStb <= 1'b0;
		#1 d = toolRdData;
	endtask
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ocd_pkg::*;
	logic ref_clk, srst, nvInit, progModePin, toolWrStb, toolRdStb;
	logic userEraseDone, userEraseReq, swWatchdogEn, stopEntry;
	logic stopEntryReset, stopEntryResetSel, watchdogKindSel, watchdogHwOn;
	logic watchdogActive, clockSafetyDisable, clockSafetyEn;
	logic lowSupplyDetectorEn, auxSupplyDetectorEn, voltageThresholdHighest;
	logic voltageLevelUnused, readoutLockN, readoutProtect, unsupportedCombo;
	logic resetDelaySel, freqDoublerEn;
	logic [1:0]  toolAddr, voltageDetectLevel, packageSel, clockSourceSel;
	logic [2:0]  oscillatorRangeSel;
	logic [7:0]  toolWrData, toolRdData, d, p0, p1;
	logic [12:0] resetDelayCycles;
	// the tool never pairs read-out lock with an enabled low supply detector
	logic [7:0]  c0 [2] = '{8'h07, 8'hD8};
	logic [7:0]  c1 [2] = '{8'h02, 8'h57};
	int mismatches, num_checks, n;
	wire logic [31:0] dec = {stopEntryResetSel, watchdogKindSel,
		watchdogHwOn, clockSafetyEn, voltageDetectLevel, lowSupplyDetectorEn,
		voltageThresholdHighest, voltageLevelUnused, packageSel, readoutProtect,
		unsupportedCombo, resetDelayCycles, clockSourceSel, oscillatorRangeSel,
		freqDoublerEn};
	ocd_option_decoder ocd_option_decoder_i (.*);
	ocd_tool_model ocd_tool_model_i (.*);
	function automatic logic [31:0] exp(input logic [7:0] b0, b1);
		logic on;
		on = b0[4:3] != 2'b11;
		return {b0[7], b0[6], !b0[6], !b0[5], b0[4:3], on, b0[4:3] == 2'b00,
			b0[4] ^ b0[3], b1[7], b0[1], !b0[0], !b0[0] & on,
			b1[6] ? 13'h0100 : 13'h1000, b1[5:4], b1[3:1], !b1[0]};
	endfunction
	task automatic chk(input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic relatch();
		@(posedge ref_clk) srst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	initial begin
		{srst, nvInit, progModePin} = 3'b111;
		{userEraseDone, swWatchdogEn, stopEntry} = 3'b000;
		repeat (2) @(posedge ref_clk);
		nvInit <= 1'b0;
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1 chk(dec, exp(OCD_SHIP_OPT0, OCD_SHIP_OPT1));
		ocd_tool_model_i.rd(OCD_OFF_OPT1, d);
		chk(d, OCD_SHIP_OPT1);
		@(posedge ref_clk) progModePin <= 1'b0;
		repeat (4) @(posedge ref_clk);
		ocd_tool_model_i.wr(OCD_OFF_OPT0, 8'h00);
		ocd_tool_model_i.rd(OCD_OFF_OPT0, d);
		chk(d, 8'h00);
		@(posedge ref_clk) progModePin <= 1'b1;
		repeat (3) @(posedge ref_clk);
		{p0, p1} = {OCD_SHIP_OPT0, OCD_SHIP_OPT1};
		for (int i = 0; i < 2; i++) begin
			ocd_tool_model_i.wr(OCD_OFF_OPT0, c0[i]);
			ocd_tool_model_i.wr(OCD_OFF_OPT1, c1[i]);
			ocd_tool_model_i.rd(OCD_OFF_OPT0, d);
			chk(d, c0[i]);
			chk(dec, exp(p0, p1));
			relatch();
			chk(dec, exp(c0[i], c1[i]));
			chk({clockSafetyDisable, auxSupplyDetectorEn, readoutLockN,
				resetDelaySel, watchdogActive}, {c0[i][5],
				c0[i][4:3] != 2'b11, c0[i][0], c1[i][6],
				!c0[i][6] | swWatchdogEn});
			{p0, p1} = {c0[i], c1[i]};
			@(posedge ref_clk) {stopEntry, swWatchdogEn} <= 2'b11;
			@(posedge ref_clk) stopEntry <= 1'b0;
			#1 chk(stopEntryReset, c0[i][7]);
		end
		ocd_tool_model_i.wr(OCD_OFF_CMD, 8'h01);
		for (n = 0; n < 20 && userEraseReq !== 1'b1; n++)
			@(posedge ref_clk);
		if (n == 20) begin
			mismatches++;
			end_sim();
		end
		chk(userEraseReq, 1'b1);
		ocd_tool_model_i.rd(OCD_OFF_STATUS, d);
		chk(d[2:0], 3'b111);
		ocd_tool_model_i.rd(OCD_OFF_OPT0, d);
		chk(d, c0[1]);
		@(posedge ref_clk) userEraseDone <= 1'b1;
		@(posedge ref_clk) userEraseDone <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk(userEraseReq, 1'b0);
		ocd_tool_model_i.rd(OCD_OFF_OPT1, d);
		chk(d, OCD_ERASED);
		relatch();
		chk(dec, exp(OCD_ERASED, OCD_ERASED));
		end_sim();
	end
endmodule
`default_nettype wire
